/* File: src/vpn_arb_if.sv */
// Carrier between the register block and one priority arbiter.
// Assumes one instance per interrupt type, all signals on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface vpn_arb_if;
	logic [27:0] req;
	logic [95:0] prio;
	logic [7:0] svc;
	logic nestEn;
	logic hit;
	logic [4:0] idx;
	logic [2:0] lvl;

	modport arbiter (input req, input prio, input svc, input nestEn,
		output hit, output idx, output lvl);
	modport client (output req, output prio, output svc, output nestEn,
		input hit, input idx, input lvl);
endinterface : vpn_arb_if

`default_nettype wire

/* File: src/vpn_arbiter.sv */
// Combinational priority arbiter for one interrupt type.
// Assumes requests are already enabled and masked by the rest of the controller.
`timescale 1ns/1ps
`default_nettype none
`include "vpn_consts.svh"

module vpn_arbiter (
	vpn_arb_if.arbiter arb
);
	import vpn_pkg::*;

	logic [2:0] effLvl [`VPN_NUM_SRC];
	logic [`VPN_NUM_SRC-1:0] elig;
	logic [3:0] svcTop;

	assign svcTop = vpn_lowest_set(arb.svc);

	// Sources without a field (0 and above 21) sit at level 0.
	genvar g;
	generate
		for (g = 0; g < `VPN_NUM_SRC; g++) begin : gSrc
			if (g == 0 || g >= `VPN_NUM_NORM_SRC) begin : gFixed
				assign effLvl[g] = 3'h0; // see R02
			end else begin : gProg
				assign effLvl[g] = arb.nestEn ? arb.prio[4*g +: 3] : 3'h0; // see R06
			end
			assign elig[g] = arb.req[g] &
				~(arb.nestEn & svcTop[3] & (effLvl[g] >= svcTop[2:0])); // see R09
		end
	endgenerate

	always_comb begin
		arb.hit = 1'b0;
		arb.idx = 5'h00;
		arb.lvl = 3'h0;
		for (int i = 0; i < `VPN_NUM_SRC; i++) begin
			// Strict compare keeps the lowest source number on a tie.
			if (elig[i] && (!arb.hit || effLvl[i] < arb.lvl)) begin // see R17
				arb.hit = 1'b1;
				arb.idx = i[4:0]; // see R12
				arb.lvl = effLvl[i];
			end
		end
	end

endmodule : vpn_arbiter

`default_nettype wire

/* File: src/vpn_consts.svh */
// Constants for the interrupt priority and nesting block: offsets, masks,
// field positions and reset values. Definitions only, no logic.
`ifndef VPN_CONSTS_SVH
`define VPN_CONSTS_SVH

`define VPN_OFF_BASE 32'hFFFF0014
`define VPN_OFF_NVEC 32'hFFFF001C
`define VPN_OFF_PRIO_A 32'hFFFF0020
`define VPN_OFF_PRIO_B 32'hFFFF0024
`define VPN_OFF_PRIO_C 32'hFFFF0028
`define VPN_OFF_NCTL 32'hFFFF0030
`define VPN_OFF_NSVC 32'hFFFF003C
`define VPN_OFF_FVEC 32'hFFFF011C
`define VPN_OFF_FSVC 32'hFFFF013C

`define VPN_MASK_PRIO_A 32'h77777770
`define VPN_MASK_PRIO_B 32'h77777777
`define VPN_MASK_PRIO_C 32'h00777777
`define VPN_MASK_NCTL 2'h3
`define VPN_RST_WORD 32'h00000000

`define VPN_NCTL_NORM_BIT 0
`define VPN_NCTL_FAST_BIT 1
`define VPN_NUM_SRC 28
`define VPN_NUM_NORM_SRC 22
`define VPN_MAX_FAST_IDX 5'h1B
`define VPN_MAX_NORM_IDX 5'h15

`endif

/* File: src/vpn_nesting_top.sv */
// Priority, nesting and vector registers of the vectored interrupt controller.
// Assumes an APB master on mclk and enabled request levels from the controller.
//
// Functional notes
// R01 - Priority A fields for sources one to seven.
// R02 - Source zero has no level, low nibble ignored.
// R03 - Priority B fields for sources eight to fifteen.
// R04 - Priority C fields for sources sixteen to 21.
// R05 - Nesting control: bit 0 normal, bit 1 fast.
// R06 - Nesting off: deliver, no levels, fast outranks normal.
// R07 - Reset clears all registers to zero.
// R08 - Normal vector read sets normal in-service bit.
// R09 - In-service level blocks equal and lower levels.
// R10 - In-service write clears only lowest set bit.
// R11 - Fast vector: base, index, zero reserved bits.
// R12 - Fast index is source number, zero to 27.
// R13 - Software reads fast vector only while nesting.
// R14 - Fast vector read sets fast in-service bit.
// R15 - Vector base holds sixteen bits, upper zero.
// R16 - Normal vector: base and index zero to 21.
// R17 - Equal levels pick the lowest source number.
// R18 - Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "vpn_consts.svh"

module vpn_nesting_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [21:0] normalSrc,
	input wire logic [27:0] fastSrc,
	output logic irqReq,
	output logic fiqReq
);
	import vpn_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	vpn_state_t st;
	vpn_state_t nxt;
	vpn_sel_t sel;
	logic accStart;
	logic accDone;
	logic [3:0] clrTop;
	logic [3:0] fClrTop;

	vpn_arb_if nArb ();
	vpn_arb_if fArb ();

	function automatic vpn_sel_t decode(input logic [31:0] a);
		case (a)
			`VPN_OFF_BASE: decode = SEL_BASE;
			`VPN_OFF_NVEC: decode = SEL_NVEC;
			`VPN_OFF_PRIO_A: decode = SEL_PRIO_A;
			`VPN_OFF_PRIO_B: decode = SEL_PRIO_B;
			`VPN_OFF_PRIO_C: decode = SEL_PRIO_C;
			`VPN_OFF_NCTL: decode = SEL_NCTL;
			`VPN_OFF_NSVC: decode = SEL_NSVC;
			`VPN_OFF_FVEC: decode = SEL_FVEC;
			`VPN_OFF_FSVC: decode = SEL_FSVC;
			default: decode = SEL_NONE;
		endcase
	endfunction : decode

	////////////////////////////////////////////////////////////////////////////

	assign nArb.req = {6'h00, normalSrc};
	assign nArb.prio = {st.prioC, st.prioB, st.prioA};
	assign nArb.svc = st.normSvc;
	assign nArb.nestEn = st.nestCtl[`VPN_NCTL_NORM_BIT];
	assign fArb.req = fastSrc;
	assign fArb.prio = {st.prioC, st.prioB, st.prioA};
	assign fArb.svc = st.fastSvc;
	assign fArb.nestEn = st.nestCtl[`VPN_NCTL_FAST_BIT];

	vpn_arbiter uNormArb (
		.arb(nArb)
	);

	vpn_arbiter uFastArb (
		.arb(fArb)
	);

	////////////////////////////////////////////////////////////////////////////

	assign sel = decode(paddr);
	// One wait state: the answer comes in the second access cycle.
	assign accStart = psel & penable & ~st.ready;
	assign accDone = psel & penable & st.ready;
	assign clrTop = vpn_lowest_set(st.normSvc);
	assign fClrTop = vpn_lowest_set(st.fastSvc);

	always_comb begin
		nxt = st;
		nxt.ready = accStart;
		nxt.slverr = accStart & (sel == SEL_NONE);
		if (accStart) begin
			nxt.rdata = 32'h00000000;
			nxt.capHit = 1'b0;
			nxt.capLvl = 3'h0;
			if (!pwrite) begin
				case (sel)
					SEL_BASE: nxt.rdata = {16'h0000, st.base}; // see R15
					SEL_NVEC: begin
						nxt.rdata = {9'h000, st.base, nArb.idx, 2'h0}; // see R16
						nxt.capHit = nArb.hit & st.nestCtl[`VPN_NCTL_NORM_BIT];
						nxt.capLvl = nArb.lvl;
					end
					SEL_PRIO_A: nxt.rdata = st.prioA;
					SEL_PRIO_B: nxt.rdata = st.prioB;
					SEL_PRIO_C: nxt.rdata = st.prioC;
					SEL_NCTL: nxt.rdata = {30'h00000000, st.nestCtl}; // see R18
					SEL_NSVC: nxt.rdata = {24'h000000, st.normSvc};
					SEL_FVEC: begin
						nxt.rdata = {9'h000, st.base, fArb.idx, 2'h0}; // see R11
						nxt.capHit = fArb.hit & st.nestCtl[`VPN_NCTL_FAST_BIT];
						nxt.capLvl = fArb.lvl;
					end
					SEL_FSVC: nxt.rdata = {24'h000000, st.fastSvc};
					default: nxt.rdata = 32'h00000000;
				endcase
			end
		end
		if (accDone && pwrite) begin
			case (sel)
				SEL_BASE: nxt.base = pwdata[15:0]; // see R15
				SEL_PRIO_A: nxt.prioA = pwdata & `VPN_MASK_PRIO_A; // see R01, R02
				SEL_PRIO_B: nxt.prioB = pwdata & `VPN_MASK_PRIO_B; // see R03
				SEL_PRIO_C: nxt.prioC = pwdata & `VPN_MASK_PRIO_C; // see R04
				SEL_NCTL: nxt.nestCtl = pwdata[1:0] & `VPN_MASK_NCTL; // see R05
				SEL_NSVC: begin
					// Any written value clears one level only, so nested exits unwind in order.
					if (clrTop[3]) begin
						nxt.normSvc[clrTop[2:0]] = 1'b0; // see R10
					end
				end
				SEL_FSVC: begin
					if (fClrTop[3]) begin
						nxt.fastSvc[fClrTop[2:0]] = 1'b0; // see R14
					end
				end
				default: nxt.base = st.base;
			endcase
		end
		// The level was captured with the data, so the bit matches the vector returned.
		if (accDone && !pwrite && st.capHit) begin
			if (sel == SEL_NVEC) begin
				nxt.normSvc[st.capLvl] = 1'b1; // see R08
			end
			if (sel == SEL_FVEC) begin
				nxt.fastSvc[st.capLvl] = 1'b1; // see R14, R13
			end
		end
		nxt.fiqOut = fArb.hit;
		nxt.irqOut = nArb.hit & ~fArb.hit; // see R06
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st <= '0; // see R07
		end else begin
			st <= nxt;
		end
	end

	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.slverr;
	assign irqReq = st.irqOut;
	assign fiqReq = st.fiqOut;

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	AST_PRIO_A_WRITE: assert property ( // see R01
		accDone && pwrite && sel == SEL_PRIO_A |=>
			st.prioA == ($past(pwdata) & `VPN_MASK_PRIO_A))
		else $error("priority A write not stored as masked");

	AST_PRIO_A_LOW: assert property ( // see R02
		st.prioA[3:0] == 4'h0)
		else $error("priority A low nibble not zero");

	AST_PRIO_B_WRITE: assert property ( // see R03
		accDone && pwrite && sel == SEL_PRIO_B |=>
			st.prioB == ($past(pwdata) & `VPN_MASK_PRIO_B))
		else $error("priority B write not stored as masked");

	AST_PRIO_C_WRITE: assert property ( // see R04
		accDone && pwrite && sel == SEL_PRIO_C |=>
			st.prioC == ($past(pwdata) & `VPN_MASK_PRIO_C) && st.prioC[31:23] == 9'h000)
		else $error("priority C write wrong or reserved bits set");

	AST_NCTL_READ: assert property ( // see R05
		accStart && !pwrite && sel == SEL_NCTL |=>
			pready && prdata == {30'h00000000, $past(st.nestCtl)})
		else $error("nesting control read wrong");

	AST_FIQ_OVER_IRQ: assert property ( // see R06
		fiqReq |-> !irqReq)
		else $error("normal request shown beside fast request");

	AST_NO_NEST_OFF: assert property ( // see R06
		accDone && !pwrite && sel == SEL_NVEC && !st.nestCtl[0] && !st.capHit |=>
			st.normSvc == $past(st.normSvc))
		else $error("in-service changed with nesting off");

	AST_RESET_CLEAR: assert property ( // see R07
		@(posedge mclk) $past(reset) |->
			st.prioA == 32'h00000000 && st.nestCtl == 2'h0 && st.normSvc == 8'h00 &&
			st.fastSvc == 8'h00 && !pready)
		else $error("registers not cleared by reset");

	AST_NORM_SET: assert property ( // see R08
		accDone && !pwrite && sel == SEL_NVEC && st.capHit |=>
			st.normSvc[$past(st.capLvl)])
		else $error("normal in-service bit not set on vector read");

	AST_BLOCK_LEVEL: assert property ( // see R09
		nArb.hit && st.nestCtl[0] && clrTop[3] |-> nArb.lvl < clrTop[2:0])
		else $error("blocked normal level selected");

	AST_CLEAR_ONE: assert property ( // see R10
		accDone && pwrite && sel == SEL_NSVC && st.normSvc != 8'h00 |=>
			$countones(st.normSvc) == $countones($past(st.normSvc)) - 1)
		else $error("in-service write did not clear exactly one bit");

	AST_FVEC_FORMAT: assert property ( // see R11
		accStart && !pwrite && sel == SEL_FVEC |=>
			prdata[31:23] == 9'h000 && prdata[1:0] == 2'h0 &&
			prdata[22:7] == $past(st.base))
		else $error("fast vector format wrong");

	AST_FVEC_RANGE: assert property ( // see R12
		accStart && !pwrite && sel == SEL_FVEC |=>
			prdata[6:2] <= `VPN_MAX_FAST_IDX)
		else $error("fast vector index out of range");

	AST_FAST_SET: assert property ( // see R14
		accDone && !pwrite && sel == SEL_FVEC && st.capHit |=>
			st.fastSvc[$past(st.capLvl)])
		else $error("fast in-service bit not set on vector read");

	AST_BASE_READ: assert property ( // see R15
		accStart && !pwrite && sel == SEL_BASE |=> prdata[31:16] == 16'h0000)
		else $error("vector base upper bits not zero");

	AST_NVEC_RANGE: assert property ( // see R16
		accStart && !pwrite && sel == SEL_NVEC |=>
			prdata[6:2] <= `VPN_MAX_NORM_IDX && prdata[22:7] == $past(st.base))
		else $error("normal vector wrong");

	AST_NCTL_RSVD: assert property ( // see R18
		accDone && pwrite && sel == SEL_NCTL |=> st.nestCtl == $past(pwdata[1:0]))
		else $error("nesting control write wrong");

	AST_ANSWER: assert property (
		accStart |=> pready ##1 !pready)
		else $error("answer not one cycle after access start");

	AST_FAST_BLOCK: assert property ( // see R14
		fArb.hit && st.nestCtl[1] && fClrTop[3] |-> fArb.lvl < fClrTop[2:0])
		else $error("blocked fast level selected");

	AST_FAST_CLEAR_ONE: assert property ( // see R14
		accDone && pwrite && sel == SEL_FSVC |=>
			st.fastSvc == ($past(st.fastSvc) & ($past(st.fastSvc) - 8'h01)))
		else $error("fast in-service write did not clear the lowest set bit");

	AST_CLEAR_LOWEST: assert property ( // see R10
		accDone && pwrite && sel == SEL_NSVC |=>
			st.normSvc == ($past(st.normSvc) & ($past(st.normSvc) - 8'h01)))
		else $error("normal in-service write did not clear the lowest set bit");

	AST_FVEC_SOURCE: assert property ( // see R12
		fArb.hit |-> fArb.req[fArb.idx])
		else $error("fast index names a source that is not requesting");

	AST_NVEC_SOURCE: assert property ( // see R16
		nArb.hit |-> nArb.req[nArb.idx] && nArb.idx <= `VPN_MAX_NORM_IDX)
		else $error("normal index names a source that is not requesting");

	AST_FIQ_QUIET: assert property ( // see R06
		$past(fastSrc) == 28'h0000000 |-> !fiqReq)
		else $error("fast request shown with no fast source");

	AST_IRQ_QUIET: assert property ( // see R06
		$past(normalSrc) == 22'h000000 |-> !irqReq)
		else $error("normal request shown with no normal source");

	AST_ERR_DATA: assert property ( // see R18
		pslverr |-> pready && prdata == 32'h00000000)
		else $error("error answer without ready or with data");

	AST_FAST_OFF_KEEP: assert property ( // see R06
		accDone && !pwrite && sel == SEL_FVEC && !st.nestCtl[1] |=>
			st.fastSvc == $past(st.fastSvc))
		else $error("fast in-service changed with nesting off");

endmodule : vpn_nesting_top

`default_nettype wire

/* File: src/vpn_pkg.sv */
// Types and shared helpers of the interrupt priority and nesting block.
// Assumes the constants header is on the include path.
package vpn_pkg;

	typedef enum logic [3:0] {
		SEL_NONE = 4'b0000,
		SEL_BASE = 4'b0001,
		SEL_NVEC = 4'b0010,
		SEL_PRIO_A = 4'b0011,
		SEL_PRIO_B = 4'b0100,
		SEL_PRIO_C = 4'b0101,
		SEL_NCTL = 4'b0110,
		SEL_NSVC = 4'b0111,
		SEL_FVEC = 4'b1000,
		SEL_FSVC = 4'b1001
	} vpn_sel_t;

	typedef struct packed {
		logic [31:0] prioA;
		logic [31:0] prioB;
		logic [31:0] prioC;
		logic [1:0] nestCtl;
		logic [7:0] normSvc;
		logic [7:0] fastSvc;
		logic [15:0] base;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irqOut;
		logic fiqOut;
		logic capHit;
		logic [2:0] capLvl;
	} vpn_state_t;

	// Returns {found, index} of the lowest set bit, which is the highest level in service.
	function automatic logic [3:0] vpn_lowest_set(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, i[2:0]};
			end
		end
		return r;
	endfunction : vpn_lowest_set

endpackage : vpn_pkg

/* File: tb/testbench.sv */
// Self-checking bench for the priority and nesting block, driven over APB.
// Assumes the design sources and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "vpn_consts.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic retSvc = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [21:0] normalSrc = 22'h0;
	logic [27:0] fastSrc = 28'h0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irqReq, fiqReq, inFiq;
	logic [33:0] note;
	logic [33:0] expQ[$];
	logic [15:0] base = 16'h0;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] regAddr[5] = '{`VPN_OFF_PRIO_A, `VPN_OFF_PRIO_B, `VPN_OFF_PRIO_C, `VPN_OFF_BASE,
		`VPN_OFF_NCTL};
	logic [31:0] regMask[5] = '{`VPN_MASK_PRIO_A, `VPN_MASK_PRIO_B, `VPN_MASK_PRIO_C, 32'h0000FFFF,
		32'h00000003};

	vpn_nesting_top u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .normalSrc(normalSrc), .fastSrc(fastSrc), .irqReq(irqReq),
		.fiqReq(fiqReq));
	vpn_core_model #(.DLY(3)) u_core (.mclk(mclk), .fiqReq(fiqReq), .retSvc(retSvc), .inFiq(inFiq));

	initial forever #4 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report

	function automatic logic [31:0] vec(input logic [4:0] idx);
		return {9'h000, base, idx, 2'h0};
	endfunction : vec

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dt,
		input logic [31:0] ex, input logic er);
		int k;
		expQ.push_back({w, er, ex});
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_mismatch++;
			final_report();
		end
	endtask : apb

	task automatic rd(input logic [31:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0, ex, 1'b0);
	endtask : rd

	task automatic wr(input logic [31:0] a, input logic [31:0] dt);
		apb(1'b1, a, dt, 32'h0, 1'b0);
	endtask : wr

	// Requests settle one edge after a change, so two edges leave margin on both outputs.
	task automatic src(input logic [21:0] n, input logic [27:0] f, input logic ei, input logic ef);
		@(posedge mclk);
		normalSrc <= n;
		fastSrc <= f;
		repeat (2) @(posedge mclk);
		`CHK("irqReq", ei, irqReq)
		`CHK("fiqReq", ef, fiqReq)
	endtask : src

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = expQ.pop_front();
			`CHK("pslverr", note[32], pslverr)
			if (!note[33]) `CHK("prdata", note[31:0], prdata)
		end
	end

	initial begin
		int i;
		logic [31:0] d;
		d = $urandom(30891);
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		for (i = 0; i < 5; i++) rd(regAddr[i], 32'h0);
		rd(`VPN_OFF_NSVC, 32'h0);
		rd(`VPN_OFF_FVEC, 32'h0);
		$display("test reset done");
		for (i = 0; i < 5; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : $urandom;
			wr(regAddr[i], d);
			rd(regAddr[i], d & regMask[i]);
		end
		apb(1'b0, 32'hFFFF0018, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 32'hFFFF0018, 32'hFFFFFFFF, 32'h0, 1'b1);
		$display("test registers done");
		base = 16'($urandom);
		wr(`VPN_OFF_BASE, {16'h0000, base});
		wr(`VPN_OFF_PRIO_A, 32'h03030050);
		wr(`VPN_OFF_NCTL, 32'h0);
		src(22'h000052, 28'h0, 1'b1, 1'b0);
		rd(`VPN_OFF_NVEC, vec(5'h01));
		rd(`VPN_OFF_NSVC, 32'h0);
		src(22'h000052, 28'h0000010, 1'b0, 1'b1);
		$display("test flat done");
		wr(`VPN_OFF_NCTL, 32'h1);
		src(22'h000052, 28'h0, 1'b1, 1'b0);
		rd(`VPN_OFF_NVEC, vec(5'h04));
		rd(`VPN_OFF_NSVC, 32'h8);
		src(22'h000052, 28'h0, 1'b0, 1'b0);
		src(22'h000056, 28'h0, 1'b1, 1'b0);
		rd(`VPN_OFF_NVEC, vec(5'h02));
		rd(`VPN_OFF_NSVC, 32'h9);
		wr(`VPN_OFF_NSVC, 32'hFF);
		rd(`VPN_OFF_NSVC, 32'h8);
		wr(`VPN_OFF_NSVC, 32'hFF);
		rd(`VPN_OFF_NSVC, 32'h0);
		$display("test normal nesting done");
		wr(`VPN_OFF_NCTL, 32'h2);
		src(22'h0, 28'h0000010, 1'b0, 1'b1);
		for (i = 0; i < 20 && inFiq !== 1'b1; i++) @(posedge mclk);
		`CHK("inFiq", 1'b1, inFiq)
		if (inFiq !== 1'b1) final_report();
		rd(`VPN_OFF_FVEC, vec(5'h04));
		rd(`VPN_OFF_FSVC, 32'h8);
		src(22'h0, 28'h0000010, 1'b0, 1'b0);
		src(22'h0, 28'h8000010, 1'b0, 1'b1);
		rd(`VPN_OFF_FVEC, vec(5'h1B));
		wr(`VPN_OFF_FSVC, 32'hFF);
		rd(`VPN_OFF_FSVC, 32'h8);
		retSvc <= 1'b1;
		@(posedge mclk);
		retSvc <= 1'b0;
		$display("test fast nesting done");
		final_report();
	end
endmodule : testbench

`default_nettype wire

/* File: tb/vpn_core_model.sv */
// Processor core stand-in that enters fast service once the request has stood a while.
// Assumes request levels on mclk; the bench signals the return from service.
`timescale 1ns/1ps
`default_nettype none

module vpn_core_model #(
	parameter int DLY = 3
) (
	input wire logic mclk,
	input wire logic fiqReq,
	input wire logic retSvc,
	output logic inFiq
);
	int cnt_ff = 0;
	logic inFiq_ff = 1'b0;
	assign inFiq = inFiq_ff;
	// A slow core lets the request stand several cycles, so a late design still gets taken.
	always @(posedge mclk) begin
		cnt_ff <= fiqReq ? cnt_ff + 1 : 0;
		if (retSvc) begin
			inFiq_ff <= 1'b0;
		end else if (fiqReq && cnt_ff >= DLY) begin
			inFiq_ff <= 1'b1;
		end
	end
endmodule : vpn_core_model

`default_nettype wire
